/* File: src/edge_sync.sv */
// two-flop synchroniser with rising-edge pulse, one per bit
// assumes inputs are slow against sys_clk (period of at least four cycles)
`timescale 1ns/100ps
module edge_sync #(
   parameter int unsigned W = 1
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out,
   output logic [W-1:0] rise_out
);
   import timer_pkg::*;
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;
   // first stage read only by the second
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end
   assign level_out = sync_q;
   assign rise_out = sync_q & ~prev_q;
endmodule : edge_sync

/* File: src/overflow_flag.sv */
// overflow flag with read-then-write-zero clear, rearmed by a fresh overflow
// assumes one-cycle strobes from the register port
`timescale 1ns/100ps
module overflow_flag (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ovf_event,
   input wire logic sc_read,
   input wire logic sc_write,
   input wire logic wr_bit,
   output logic flag
);
   import timer_pkg::*;
   logic flag_q;
   clr_state_t st_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= CLR_IDLE;
      end else if (ovf_event) begin
         st_q <= CLR_IDLE; // RULE3
      end else begin
         case (st_q)
            CLR_IDLE: begin
               if (sc_read && flag_q) begin
                  st_q <= CLR_ARMED; // RULE2
               end
            end
            CLR_ARMED: begin
               if (sc_write) begin
                  st_q <= CLR_IDLE;
               end
            end
            default: begin
               st_q <= CLR_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag_q <= 1'b0; // RULE4
      end else if (ovf_event) begin
         flag_q <= 1'b1; // RULE1
      end else if (sc_write && st_q == CLR_ARMED && !wr_bit) begin
         flag_q <= 1'b0; // RULE2
      end
   end
   // a one written to the flag never reaches flag_q
   assign flag = flag_q; // RULE4
endmodule : overflow_flag

/* File: src/timer_overflow_mode_control.sv */
// timer status/control: 16-bit counter, overflow flag, interrupt and counting mode
// assumes a synchronous byte register port with read data one cycle after the strobe
// ==========================================
// Summary of operation
// RULE1 - overflow flag sets when counter wraps to 0x0000 after reaching modulo.
// RULE2 - flag clears by reading the register while set, then writing zero.
// RULE3 - a new overflow mid-sequence restarts clearing so the flag stays set.
// RULE4 - writing one to the flag does nothing; reset clears the flag.
// RULE5 - interrupt request while flag and enable are both set; reset clears enable.
// RULE6 - select clear: counter counts up, channels follow their own mode bits.
// RULE7 - select set: counter counts up then down, all channels center-aligned; reset clears.
// RULE8 - flag bit 7, enable bit 6, select bit 5, all readable and writable.
// RULE9 - status/control settings apply to all channels of the timer together.
// RULE10 - external clock and capture inputs pass bus-clock synchronisers; period at least 4.
// RULE11 - counter is 16 bits, compared with a 16-bit modulo value.
`timescale 1ns/100ps
module timer_overflow_mode_control (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [timer_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [timer_pkg::DATA_W-1:0] reg_rdata,
   input wire logic ext_clk,
   input wire logic [timer_pkg::CHAN_N-1:0] capture_in,
   output logic overflow_irq,
   output logic irq,
   output logic count_down,
   output logic [timer_pkg::CHAN_N-1:0] chan_center_aligned,
   output logic [timer_pkg::CHAN_N*2-1:0] chan_mode
);
   import timer_pkg::*;

   // ==========================================
   // register state
   logic ovf_ie_q;
   logic center_q;
   logic ext_sel_q;
   logic [CNT_W-1:0] modulo_q;
   logic [CNT_W-1:0] count_q;
   logic down_q;
   logic [DATA_W-1:0] mask_q;
   logic [DATA_W-1:0] irq_stat_q;
   logic [DATA_W-1:0] mode_q;
   logic [DATA_W-1:0] rdata_q;
   logic flag;
   logic ovf_event;
   logic tick;
   logic ext_rise;
   logic [CHAN_N-1:0] cap_level;
   logic [CHAN_N-1:0] cap_rise;
   logic sc_rd;
   logic sc_wr;
   logic at_mod;
   logic at_zero;

   assign sc_rd = reg_rd && reg_addr == OFS_STATUS_CONTROL;
   assign sc_wr = reg_wr && reg_addr == OFS_STATUS_CONTROL;

   // ==========================================
   // input synchronisers
   // sampling at bus rate limits the external clock to a quarter of it
   edge_sync #(.W(1)) u_ext_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(ext_clk),
      .level_out(),
      .rise_out(ext_rise)
   ); // RULE10
   edge_sync #(.W(CHAN_N)) u_cap_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(capture_in),
      .level_out(cap_level),
      .rise_out(cap_rise)
   ); // RULE10

   assign tick = ext_sel_q ? ext_rise : 1'b1;

   // ==========================================
   // counter
   assign at_mod = count_q == modulo_q; // RULE11
   assign at_zero = count_q == WRAP_VALUE;
   // up mode overflows on wrap to zero; up/down mode overflows at the bottom turn
   assign ovf_event = tick && (center_q ? (down_q && at_zero) : at_mod); // RULE1

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count_q <= WRAP_VALUE;
         down_q <= 1'b0;
      end else if (tick) begin
         if (!center_q) begin
            down_q <= 1'b0; // RULE6
            count_q <= at_mod ? WRAP_VALUE : count_q + 16'h0001; // RULE1
         end else if (!down_q) begin
            if (at_mod) begin
               down_q <= 1'b1; // RULE7
               count_q <= count_q - 16'h0001;
            end else begin
               count_q <= count_q + 16'h0001;
            end
         end else begin
            if (at_zero) begin
               down_q <= 1'b0; // RULE7
               count_q <= count_q + 16'h0001;
            end else begin
               count_q <= count_q - 16'h0001;
            end
         end
      end
   end

   // ==========================================
   // overflow flag
   overflow_flag u_flag (
      .sys_clk(sys_clk),
      .srst(srst),
      .ovf_event(ovf_event),
      .sc_read(sc_rd),
      .sc_write(sc_wr),
      .wr_bit(reg_wdata[BIT_OVF]),
      .flag(flag)
   );

   // ==========================================
   // control registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ovf_ie_q <= RST_STATUS_CONTROL[BIT_OVF_IE]; // RULE5
         center_q <= RST_STATUS_CONTROL[BIT_CENTER]; // RULE7
      end else if (sc_wr) begin
         ovf_ie_q <= reg_wdata[BIT_OVF_IE]; // RULE8
         center_q <= reg_wdata[BIT_CENTER]; // RULE8
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         modulo_q <= RST_MODULO;
      end else if (reg_wr && reg_addr == OFS_MODULO_HI) begin
         modulo_q[15:8] <= reg_wdata;
      end else if (reg_wr && reg_addr == OFS_MODULO_LO) begin
         modulo_q[7:0] <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ext_sel_q <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_CLOCK_CTRL) begin
         ext_sel_q <= reg_wdata[BIT_EXT_CLK];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_q <= RST_CHAN_MODE;
      end else if (reg_wr && reg_addr == OFS_CHAN_MODE) begin
         mode_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mask_q <= RST_IRQ_MASK;
      end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
         mask_q <= reg_wdata;
      end
   end

   // ==========================================
   // sticky event status, cleared by read; a same-cycle event wins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_stat_q <= 8'h00;
      end else begin
         irq_stat_q <= ((reg_rd && reg_addr == OFS_IRQ_STATUS) ? 8'h00 : irq_stat_q)
            | {6'h00, |cap_rise, ovf_event};
      end
   end

   // ==========================================
   // read port
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_STATUS_CONTROL: rdata_q <= {flag, ovf_ie_q, center_q, 5'h00}; // RULE8
            OFS_MODULO_HI: rdata_q <= modulo_q[15:8];
            OFS_MODULO_LO: rdata_q <= modulo_q[7:0];
            OFS_COUNT_HI: rdata_q <= count_q[15:8];
            OFS_COUNT_LO: rdata_q <= count_q[7:0];
            OFS_CLOCK_CTRL: rdata_q <= {7'h00, ext_sel_q};
            OFS_IRQ_STATUS: rdata_q <= irq_stat_q;
            OFS_IRQ_MASK: rdata_q <= mask_q;
            OFS_CHAN_MODE: rdata_q <= {mode_q[DATA_W-1:CHAN_N], cap_level};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // ==========================================
   // outputs shared by every channel, then per-channel center flag and mode
   assign overflow_irq = flag && ovf_ie_q; // RULE5
   assign irq = |(irq_stat_q & mask_q);
   assign count_down = down_q;
   genvar g;
   generate
      for (g = 0; g < CHAN_N; g++) begin : g_chan
         assign chan_center_aligned[g] = center_q; // RULE9
         assign chan_mode[g*2 +: 2] = center_q ? 2'h0 : mode_q[g*2 +: 2]; // RULE6
      end
   endgenerate
endmodule : timer_overflow_mode_control

/* File: src/timer_pkg.sv */
// timer status/control package: register map, field positions, reset values, timing counts
// assumes a single 10 MHz bus clock and a byte-wide register port
package timer_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned CHAN_N = 2;
   // ==========================================
   // register offsets
   localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_MODULO_HI = 4'h1;
   localparam logic [3:0] OFS_MODULO_LO = 4'h2;
   localparam logic [3:0] OFS_COUNT_HI = 4'h3;
   localparam logic [3:0] OFS_COUNT_LO = 4'h4;
   localparam logic [3:0] OFS_CLOCK_CTRL = 4'h5;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
   localparam logic [3:0] OFS_CHAN_MODE = 4'h8;
   // ==========================================
   // field positions
   localparam int unsigned BIT_OVF = 7;
   localparam int unsigned BIT_OVF_IE = 6;
   localparam int unsigned BIT_CENTER = 5;
   localparam int unsigned BIT_EXT_CLK = 0;
   localparam int unsigned IRQ_BIT_OVF = 0;
   localparam int unsigned IRQ_BIT_CAP = 1;
   // ==========================================
   // reset values
   localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
   localparam logic [15:0] RST_MODULO = 16'hFFFF;
   localparam logic [15:0] WRAP_VALUE = 16'h0000;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] RST_CHAN_MODE = 8'h00;
   // ==========================================
   // timing
   localparam int unsigned BUS_HZ = 10_000_000;
   localparam int unsigned EXT_PERIOD_MIN_CYC = 4;
   localparam int unsigned SYNC_STAGES = 2;
   typedef enum logic [1:0] {
      CLR_IDLE = 2'b00,
      CLR_ARMED = 2'b01
   } clr_state_t;
endpackage : timer_pkg

/* File: verif/timer_overflow_mode_control_bench.sv */
// self-checking bench for the status/control block
// assumes timer_pkg and the bound checker are compiled
`timescale 1ns/100ps
module timer_overflow_mode_control_bench;
   import timer_pkg::*;
   logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, ext_clk = 0;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata;
   logic [1:0] capture_in = 0, chan_center_aligned;
   logic [3:0] chan_mode;
   logic overflow_irq, irq, count_down;
   int mismatches = 0;
   int tests_run = 0;
   timer_overflow_mode_control timer_overflow_mode_control_i (.sys_clk, .srst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .ext_clk, .capture_in, .overflow_irq, .irq, .count_down,
      .chan_center_aligned, .chan_mode);
   always #50 sys_clk = ~sys_clk;
   // six-cycle period keeps the synchroniser safe
   always begin
      repeat (3) @(posedge sys_clk);
      ext_clk <= ~ext_clk;
   end
   // ==========================================
   // bus helpers
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         mismatches++;
      end
   endtask : chk
   task automatic watch(output logic s);
      s = 1'b0;
      repeat (80) begin
         @(posedge sys_clk);
         #1 s |= count_down;
      end
   endtask : watch
   // ==========================================
   // scenarios
   task automatic t_reset;
      logic [7:0] d;
      rd(OFS_STATUS_CONTROL, d);
      chk("sc_reset", RST_STATUS_CONTROL, d);
      rd(OFS_MODULO_HI, d);
      chk("mod_reset", RST_MODULO[15:8], d);
      wr(OFS_MODULO_LO, 8'h20);
      wr(OFS_MODULO_HI, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_fields;
      logic [7:0] d;
      wr(OFS_STATUS_CONTROL, 8'h60);
      rd(OFS_STATUS_CONTROL, d);
      chk("sc_rw", 8'h60, d & 8'h7F);
      wr(OFS_CHAN_MODE, 8'h0A);
      wt(2);
      chk("center_all", 8'h03, 8'(chan_center_aligned));
      chk("mode_forced", 8'h00, 8'(chan_mode));
      wr(OFS_STATUS_CONTROL, 8'h00);
      wt(2);
      chk("mode_own", 8'h0A, 8'(chan_mode));
      wr(4'hF, 8'hFF);
      rd(4'hF, d);
      chk("unmapped", 8'h00, d);
      $display("test fields done");
   endtask : t_fields
   task automatic t_clear;
      logic [7:0] d;
      d = 8'hFF;
      // wait for a fresh wrap so the next one is far off
      for (int i = 0; i < 40 && d > 8'h02; i++) rd(OFS_COUNT_LO, d);
      rd(OFS_STATUS_CONTROL, d);
      chk("ovf_set", 8'h80, d);
      wr(OFS_STATUS_CONTROL, 8'hC0);
      wt(1);
      chk("irq_on", 8'h01, 8'(overflow_irq));
      wr(OFS_STATUS_CONTROL, 8'hC0);
      rd(OFS_STATUS_CONTROL, d);
      chk("one_kept", 8'hC0, d);
      wr(OFS_STATUS_CONTROL, 8'h40);
      rd(OFS_STATUS_CONTROL, d);
      chk("cleared", 8'h40, d);
      wt(40);
      wr(OFS_STATUS_CONTROL, 8'h40);
      rd(OFS_STATUS_CONTROL, d);
      chk("no_read", 8'hC0, d);
      wt(40);
      wr(OFS_STATUS_CONTROL, 8'h00);
      rd(OFS_STATUS_CONTROL, d);
      chk("rearm", 8'h80, d);
      chk("polled", 8'h00, 8'(overflow_irq));
      $display("test clear done");
   endtask : t_clear
   task automatic t_irq;
      logic [7:0] d;
      wr(OFS_IRQ_MASK, 8'h00);
      wt(40);
      chk("irq_masked", 8'h00, 8'(irq));
      wr(OFS_IRQ_MASK, 8'h03);
      wt(1);
      chk("irq_raised", 8'h01, 8'(irq));
      rd(OFS_IRQ_STATUS, d);
      d = 8'h00;
      for (int i = 0; i < 40 && !d[0]; i++) rd(OFS_IRQ_STATUS, d);
      wt(1);
      chk("irq_clr", 8'h00, 8'(irq));
      capture_in <= 2'b01;
      wt(6);
      rd(OFS_IRQ_STATUS, d);
      chk("capture", 8'h02, d & 8'h02);
      rd(OFS_CHAN_MODE, d);
      chk("cap_level", 8'h01, d & 8'h03);
      capture_in <= 2'b00;
      $display("test irq done");
   endtask : t_irq
   task automatic t_mode;
      logic s;
      logic [7:0] a, b, n;
      wr(OFS_STATUS_CONTROL, 8'h20);
      watch(s);
      chk("down", 8'h01, 8'(s));
      wr(OFS_STATUS_CONTROL, 8'h00);
      wt(4);
      watch(s);
      chk("up_only", 8'h00, 8'(s));
      wr(OFS_CLOCK_CTRL, 8'h01);
      rd(OFS_COUNT_LO, a);
      wt(24);
      rd(OFS_COUNT_LO, b);
      n = (b >= a) ? b - a : b + 8'h21 - a;
      chk("ext_rate", 8'h01, 8'(n >= 8'h03 && n <= 8'h05));
      wr(OFS_CLOCK_CTRL, 8'h00);
      $display("test mode done");
   endtask : t_mode
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   initial begin
      repeat (6) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset;
      t_fields;
      t_clear;
      t_irq;
      t_mode;
      conclude;
   end
   // run needs well under a thousand cycles
   initial begin
      #1_000_000;
      mismatches++;
      conclude;
   end
endmodule : timer_overflow_mode_control_bench

/* File: verif/timer_overflow_mode_control_props.sv */
// checker on the status/control block ports
// assumes it is bound to the top module
`timescale 1ns/100ps
module timer_overflow_mode_control_props (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic overflow_irq,
   input wire logic irq,
   input wire logic count_down,
   input wire logic [1:0] chan_center_aligned,
   input wire logic [3:0] chan_mode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ==========================================
   // assertions
   a_reset_quiet: assert property (disable iff (1'b0) srst |=> !overflow_irq && !irq && chan_center_aligned == 2'b00)
      else $error("outputs active after reset");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data without read");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h8 |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_readback_irq: assert property ($past(reg_rd) && $past(reg_addr) == 4'h0 && $past(overflow_irq)
      |-> reg_rdata[7:6] == 2'b11)
      else $error("flag and enable not read back");
   a_one_ignored: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[7:6] == 2'b11 && overflow_irq
      |=> overflow_irq)
      else $error("writing one changed the flag");
   a_ie_quiet: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[6] |=> !overflow_irq)
      else $error("request with enable clear");
   a_center_select: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[5] |-> ##[1:2] chan_center_aligned == 2'b11)
      else $error("center select not applied");
   a_center_joint: assert property (chan_center_aligned == {2{chan_center_aligned[0]}})
      else $error("channels disagree on mode");
   a_mode_forced: assert property (chan_center_aligned[0] && $past(chan_center_aligned[0]) |-> chan_mode == 4'h0)
      else $error("channel mode not forced");
   c_irq: cover property (overflow_irq);
   c_down: cover property (count_down);
   c_clear: cover property ($fell(overflow_irq));
endmodule : timer_overflow_mode_control_props
bind timer_overflow_mode_control timer_overflow_mode_control_props timer_overflow_mode_control_props_i (
   .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .overflow_irq, .irq, .count_down, .chan_center_aligned, .chan_mode);
